/* flash_margin_pkg.sv */
// Constants, types and register layout of the margin check command sequencer
package flash_margin_pkg;
   localparam logic [7:0] off_status = 8'h00;
   localparam logic [7:0] off_param0 = 8'h04;
   localparam logic [7:0] off_param1 = 8'h08;
   localparam logic [7:0] off_param2 = 8'h0c;
   localparam logic [7:0] off_config = 8'h10;
   localparam int param_count = 12;
   localparam logic [7:0] code_section = 8'h01;
   localparam logic [7:0] code_prog_check = 8'h02;
   localparam logic [7:0] code_resource = 8'h03;
   localparam logic [7:0] choice_normal = 8'h00;
   localparam logic [7:0] choice_user = 8'h01;
   localparam logic [7:0] choice_factory = 8'h02;
   localparam logic [7:0] rsel_info_row = 8'h00;
   localparam logic [7:0] rsel_version = 8'h01;
   localparam logic [23:0] flash_bytes = 24'h02_0000;
   localparam logic [23:0] segment_end = 24'h00_8000;
   localparam logic [23:0] info_row_bytes = 24'h00_0100;
   localparam logic [23:0] version_bytes = 24'h00_0008;
   localparam logic [23:0] phrase_bytes = 24'h00_0008;
   typedef enum logic [2:0] {
      lvl_normal = 3'h0,
      lvl_user1 = 3'h1,
      lvl_factory1 = 3'h2,
      lvl_user0 = 3'h3,
      lvl_factory0 = 3'h4
   } margin_t;
   typedef enum logic [1:0] {
      space_main = 2'h0,
      space_info_row = 2'h1,
      space_version = 2'h2
   } space_t;
   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_check = 5'b00010,
      st_read = 5'b00100,
      st_eval = 5'b01000,
      st_done = 5'b10000
   } seq_state_t;
   typedef struct packed {
      logic complete;
      logic read_collision;
      logic access_error;
      logic protection_violation;
      logic [2:0] unused;
      logic verify_fail;
   } status_t;
   typedef struct packed {
      logic [22:0] unused_hi;
      logic erased_ok;
      logic [4:0] unused_lo;
      logic segment_active;
      logic secure;
      logic special_mode;
   } config_t;
   localparam logic [7:0] status_reset = 8'h80;
   localparam logic [31:0] config_reset = 32'h0000_0000;
endpackage

/* flash_margin_seq.sv */
// Margin check command sequencer with APB register port and array read port
`timescale 1ns/10ps
module flash_margin_seq
   import flash_margin_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic array_rd,
   output logic [23:0] array_addr,
   output margin_t array_margin,
   output space_t array_space,
   input wire logic [63:0] array_rdata,
   input wire logic mcu_read,
   input wire logic full_erase_done
);
   status_t status, next_status;
   config_t cfg, next_cfg;
   logic [7:0] param [param_count];
   logic [7:0] next_param [param_count];
   seq_state_t state, next_state;
   logic [23:0] addr, next_addr;
   logic [15:0] count, next_count;
   logic second, next_second;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_rd;
   logic [23:0] next_array_addr;
   margin_t next_margin;
   space_t next_space;

   // Decoded command fields
   logic [7:0] code;
   logic [23:0] start;
   logic [15:0] phrases;
   logic [21:0] sect_end;
   logic [31:0] expected, word;
   logic unavail, sect_bad, chk_bad, chk_prot, rsrc_bad, code_bad, acc_bad;
   logic bus_write, launch;
   status_t wstat;

   assign code = param[0];
   assign start = {param[1], param[2], param[3]};
   assign phrases = {param[4], param[5]};
   assign sect_end = {1'b0, start[23:3]} + {6'h00, phrases};
   // Byte 3 is lowest address, so it lands in the low lane
   assign expected = {param[8], param[9], param[10], param[11]};
   assign word = addr[2] ? array_rdata[63:32] : array_rdata[31:0];
   assign unavail = cfg.special_mode & cfg.secure;
   assign sect_bad = unavail | (start[2:0] != 3'h0)
      | (param[6] > choice_factory)
      | (start >= flash_bytes) | (phrases == 16'h0000)
      | (sect_end > {1'b0, flash_bytes[23:3]});
   assign chk_bad = unavail | (start[1:0] != 2'h0)
      | (start >= flash_bytes)
      | ((param[4] != choice_user) && (param[4] != choice_factory));
   assign chk_prot = cfg.segment_active & (start < segment_end) & ~cfg.erased_ok;
   assign rsrc_bad = unavail | (start[1:0] != 2'h0) | (param[8] > rsel_version)
      | (start >= ((param[8] == rsel_version) ? version_bytes : info_row_bytes));
   assign code_bad = (code != code_section) && (code != code_prog_check)
      && (code != code_resource);
   always_comb
   begin
      acc_bad = code_bad;
      case (code)
         code_section: acc_bad = sect_bad;
         code_prog_check: acc_bad = chk_bad;
         code_resource: acc_bad = rsrc_bad;
         default: acc_bad = 1'b1;
      endcase
   end
   assign bus_write = psel & penable & pready & pwrite;
   assign wstat = status_t'(pwdata[7:0]);
   // Access and protection errors from the previous command block the launch
   assign launch = bus_write && (paddr == off_status) && wstat.complete && status.complete
      && !status.access_error && !status.protection_violation;

   always_comb
   begin
      next_status = status;
      next_cfg = cfg;
      next_param = param;
      next_state = state;
      next_addr = addr;
      next_count = count;
      next_second = second;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_rd = 1'b0;
      next_array_addr = array_addr;
      next_margin = array_margin;
      next_space = array_space;
      // One wait state on every access
      if (psel && penable && !pready)
      begin
         next_pready = 1'b1;
         case (paddr)
            off_status: next_prdata = {24'h00_0000, status};
            off_param0: next_prdata = {param[3], param[2], param[1], param[0]};
            off_param1: next_prdata = {param[7], param[6], param[5], param[4]};
            off_param2: next_prdata = {param[11], param[10], param[9], param[8]};
            off_config: next_prdata = cfg;
            default:
            begin
               next_prdata = 32'h0000_0000;
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (bus_write)
      begin
         case (paddr)
            off_status:
            begin
               if (wstat.access_error)
                  next_status.access_error = 1'b0;
               if (wstat.protection_violation)
                  next_status.protection_violation = 1'b0;
               if (wstat.read_collision)
                  next_status.read_collision = 1'b0;
            end
            off_param0, off_param1, off_param2:
            begin
               // Parameter writes are dropped while a command runs
               if (status.complete)
               begin
                  for (int i = 0; i < 4; i++)
                  begin
                     next_param[{paddr[3:2] - 2'h1, 2'h0} + 4'(i)] = pwdata[8 * i +: 8];
                  end
               end
            end
            off_config:
            begin
               next_cfg.special_mode = pwdata[0];
               next_cfg.secure = pwdata[1];
               next_cfg.segment_active = pwdata[2];
            end
            default: next_cfg = cfg;
         endcase
      end
      if (launch)
      begin
         next_status.complete = 1'b0;
         next_status.verify_fail = 1'b0;
         next_state = st_check;
      end
      // Hardware sets come last so they win over a clear
      if (full_erase_done)
         next_cfg.erased_ok = 1'b1;
      if (mcu_read && !status.complete)
         next_status.read_collision = 1'b1;
      case (state)
         st_idle: next_margin = lvl_normal;
         st_check:
         begin
            if (acc_bad || (code == code_prog_check && chk_prot))
            begin
               next_status.access_error = next_status.access_error | acc_bad;
               next_status.protection_violation = next_status.protection_violation
                  | ((code == code_prog_check) & chk_prot);
               next_state = st_done;
            end
            else
            begin
               next_addr = start;
               next_count = phrases;
               next_second = 1'b0;
               next_rd = 1'b1;
               next_array_addr = start;
               next_space = space_main;
               next_state = st_read;
               case (code)
                  code_section: next_margin = margin_t'(param[6][2:0]);
                  code_prog_check: next_margin = (param[4] == choice_user) ? lvl_user1
                     : lvl_factory1;
                  default:
                  begin
                     next_margin = lvl_normal;
                     next_space = (param[8] == rsel_version) ? space_version : space_info_row;
                  end
               endcase
            end
         end
         st_read: next_state = st_eval;
         st_eval:
         begin
            next_state = st_done;
            case (code)
               code_section:
               begin
                  if (array_rdata != 64'hffff_ffff_ffff_ffff)
                     next_status.verify_fail = 1'b1;
                  if (count != 16'h0001)
                  begin
                     next_count = count - 16'h0001;
                     next_addr = addr + phrase_bytes;
                     next_array_addr = addr + phrase_bytes;
                     next_rd = 1'b1;
                     next_state = st_read;
                  end
               end
               code_prog_check:
               begin
                  if (word != expected)
                     next_status.verify_fail = 1'b1;
                  if (!second)
                  begin
                     next_second = 1'b1;
                     next_margin = (array_margin == lvl_user1) ? lvl_user0 : lvl_factory0;
                     next_rd = 1'b1;
                     next_state = st_read;
                  end
               end
               default:
               begin
                  next_param[4] = word[31:24];
                  next_param[5] = word[23:16];
                  next_param[6] = word[15:8];
                  next_param[7] = word[7:0];
               end
            endcase
         end
         st_done:
         begin
            next_status.complete = 1'b1;
            next_margin = lvl_normal;
            next_space = space_main;
            next_state = st_idle;
         end
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status <= status_t'(status_reset);
         cfg <= config_t'(config_reset);
         for (int i = 0; i < param_count; i++)
         begin
            param[i] <= 8'h00;
         end
         state <= st_idle;
         addr <= 24'h00_0000;
         count <= 16'h0000;
         second <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         array_rd <= 1'b0;
         array_addr <= 24'h00_0000;
         array_margin <= lvl_normal;
         array_space <= space_main;
      end
      else
      begin
         status <= next_status;
         cfg <= next_cfg;
         param <= next_param;
         state <= next_state;
         addr <= next_addr;
         count <= next_count;
         second <= next_second;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         array_rd <= next_rd;
         array_addr <= next_array_addr;
         array_margin <= next_margin;
         array_space <= next_space;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   idle_normal_a: assert property ((state == st_idle) |-> (array_margin == lvl_normal))
      else $error("margin level not normal while idle");
   bad_code_a: assert property ((state == st_check) && code_bad
      |=> status.access_error && (state == st_done))
      else $error("unknown command not rejected");
   launch_clears_a: assert property (launch
      |=> !status.complete && (state == st_check))
      else $error("launch did not clear command complete");
   launch_blocked_a: assert property (bus_write && (paddr == off_status)
      && wstat.complete && (status.access_error || status.protection_violation)
      |=> (state != st_check))
      else $error("launch accepted with error flag set");
   collision_a: assert property (mcu_read && !status.complete |=> status.read_collision)
      else $error("read collision not flagged");
   sect_zero_a: assert property ((state == st_check) && (code == code_section)
      && (phrases == 16'h0000) |=> status.access_error ##1 status.complete)
      else $error("zero phrase count not rejected");
   sect_align_a: assert property ((state == st_check) && (code == code_section)
      && (start[2:0] != 3'h0) |=> status.access_error && !array_rd)
      else $error("misaligned section start not rejected");
   chk_align_a: assert property ((state == st_check) && (code == code_prog_check)
      && (start[1:0] != 2'h0) |=> status.access_error && !array_rd)
      else $error("misaligned program check not rejected");
   chk_prot_a: assert property ((state == st_check) && (code == code_prog_check)
      && !chk_bad && chk_prot |=> status.protection_violation && !array_rd)
      else $error("controlled segment not protected");
   chk_margin_a: assert property ((state == st_eval) && (code == code_prog_check)
      && !second && (array_margin == lvl_user1) |=> array_rd && (array_margin == lvl_user0))
      else $error("program check second read not at margin-0");
   sect_fail_a: assert property ((state == st_eval) && (code == code_section)
      && (array_rdata != 64'hffff_ffff_ffff_ffff) |=> status.verify_fail)
      else $error("erased check miss not flagged");
endmodule

/* flash_array_model.sv */
// Program flash array model answering the sequencer's margin reads
`timescale 1ns/10ps
module flash_array_model
   import flash_margin_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rd,
   input wire logic [23:0] addr,
   input wire margin_t margin,
   input wire space_t space,
   output logic [63:0] rdata
);
   logic [63:0] next_rdata;
   // Outside a read the data toggles, so stale values never pass
   always_comb
   begin
      next_rdata = ~rdata;
      if (rd)
      begin
         if (space != space_main)
            next_rdata = 64'h0807060504030201;
         else if (addr == 24'h000100)
            next_rdata = 64'hffff_ffff_ffef_ffff;
         else if (addr == 24'h000200)
            next_rdata = {32'hffffffff, 32'h44332211};
         else if (addr == 24'h000300 && (margin == lvl_user1 || margin == lvl_factory1))
            next_rdata = 64'hffff_7fff_ffff_ffff; // Weak bit fails only at user or factory margin-1
         else
            next_rdata = '1;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata <= '0;
      else
         rdata <= next_rdata;
   end
endmodule

/* tb_top.sv */
// Self-checking bench for the margin check command sequencer
`timescale 1ns/10ps
module tb_top
   import flash_margin_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic array_rd, mcu_read, full_erase_done, coll;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [23:0] array_addr;
   logic [63:0] array_rdata;
   margin_t array_margin, first_m, last_m;
   space_t array_space;
   int bad_count, tests_run, nrd;
   margin_t lv[5] = '{lvl_normal, lvl_user1, lvl_factory1, lvl_user0, lvl_factory0};
   flash_margin_seq u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .array_rd(array_rd), .array_addr(array_addr),
      .array_margin(array_margin), .array_space(array_space), .array_rdata(array_rdata),
      .mcu_read(mcu_read), .full_erase_done(full_erase_done));
   flash_array_model u_array (.pclk(pclk), .presetn(presetn), .rd(array_rd),
      .addr(array_addr), .margin(array_margin), .space(array_space), .rdata(array_rdata));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (array_rd === 1'b1)
      begin
         nrd++;
         last_m = array_margin;
         if (nrd == 1) first_m = array_margin;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Request held until pready is sampled high, then released
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(32'h0, 32'h1, "no pready");
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [23:0] a, input logic [31:0] w1,
      input logic [31:0] w2, input logic [7:0] es, input int nr);
      int n;
      apb(8'h04, 1'b1, {a[7:0], a[15:8], a[23:16], c});
      apb(8'h08, 1'b1, w1);
      apb(8'h0c, 1'b1, w2);
      apb(8'h00, 1'b1, 32'h70);
      nrd = 0;
      apb(8'h00, 1'b1, 32'h80);
      if (coll) mcu_read <= 1'b1;
      apb(8'h00, 1'b0, 32'h0);
      mcu_read <= 1'b0;
      if (nr > 0) chk(32'(q[7]), 32'h0, "busy flag");
      n = 0;
      do
      begin
         apb(8'h00, 1'b0, 32'h0);
         n++;
      end
      while (q[7] !== 1'b1 && n < 40);
      chk(32'(q[7:0]), 32'(es), "status");
      chk(32'(nrd), 32'(nr), "read count");
      chk(32'(array_margin), 32'(lvl_normal), "idle margin");
   endtask
   task automatic t_reset;
      apb(8'h00, 1'b0, 32'h0);
      chk(q, 32'h80, "status reset");
      apb(8'h14, 1'b0, 32'h0);
      chk(32'(perr), 32'h1, "unmapped");
      chk(32'(array_margin), 32'(lvl_normal), "reset margin");
      $display("test reset done");
   endtask
   task automatic t_section;
      cmd(8'h01, 24'h0, 32'h0200, 32'h0, 8'h80, 2);
      cmd(8'h01, 24'hf8, 32'h0200, 32'h0, 8'h81, 2);
      for (int m = 0; m < 3; m++)
      begin
         cmd(8'h01, 24'h300, {8'h0, 8'(m), 16'h0100}, 32'h0, (m == 0) ? 8'h80 : 8'h81, 1);
         chk(32'(last_m), 32'(lv[m]), "section margin");
      end
      $display("test section done");
   endtask
   task automatic t_errors;
      cmd(8'h01, 24'h300, 32'h030100, 32'h0, 8'ha0, 0);
      cmd(8'h01, 24'h304, 32'h0100, 32'h0, 8'ha0, 0);
      cmd(8'h01, 24'h300, 32'h0, 32'h0, 8'ha0, 0);
      cmd(8'h01, 24'h1fff8, 32'h0200, 32'h0, 8'ha0, 0);
      cmd(8'h01, 24'h20000, 32'h0100, 32'h0, 8'ha0, 0);
      apb(8'h10, 1'b1, 32'h3);
      cmd(8'h01, 24'h300, 32'h0100, 32'h0, 8'ha0, 0);
      cmd(8'h02, 24'h200, 32'h1, 32'h11223344, 8'ha0, 0);
      apb(8'h10, 1'b1, 32'h0);
      $display("test errors done");
   endtask
   task automatic t_pgm;
      for (int m = 1; m < 3; m++)
      begin
         cmd(8'h02, 24'h200, 32'(m), 32'h11223344, 8'h80, 2);
         chk(32'(first_m), 32'(lv[m]), "margin-1 level");
         chk(32'(last_m), 32'(lv[m + 2]), "margin-0 level");
      end
      cmd(8'h02, 24'h200, 32'h1, 32'h44332211, 8'h81, 2);
      cmd(8'h02, 24'h200, 32'h0, 32'h11223344, 8'ha0, 0);
      cmd(8'h02, 24'h200, 32'h3, 32'h11223344, 8'ha0, 0);
      cmd(8'h02, 24'h202, 32'h1, 32'h11223344, 8'ha0, 0);
      $display("test program check done");
   endtask
   task automatic t_prot;
      apb(8'h10, 1'b1, 32'h4);
      cmd(8'h02, 24'h200, 32'h1, 32'h11223344, 8'h90, 0);
      full_erase_done <= 1'b1;
      @(posedge pclk);
      full_erase_done <= 1'b0;
      apb(8'h10, 1'b0, 32'h0);
      chk(q, 32'h104, "erased ok");
      cmd(8'h02, 24'h200, 32'h1, 32'h11223344, 8'h80, 2);
      apb(8'h10, 1'b1, 32'h0);
      $display("test protect done");
   endtask
   task automatic t_misc;
      cmd(8'h03, 24'h0, 32'h0, 32'(rsel_version), 8'h80, 1);
      apb(8'h08, 1'b0, 32'h0);
      chk(q, 32'h01020304, "resource data");
      cmd(8'h03, 24'h4, 32'h0, 32'h0, 8'h80, 1);
      apb(8'h08, 1'b0, 32'h0);
      chk(q, 32'h05060708, "info row data");
      cmd(8'h03, 24'h0, 32'h0, 32'h2, 8'ha0, 0);
      cmd(8'h06, 24'h0, 32'h0, 32'h0, 8'ha0, 0);
      nrd = 0;
      apb(8'h00, 1'b1, 32'h80);
      repeat (4) @(posedge pclk);
      apb(8'h00, 1'b0, 32'h0);
      chk(32'(q[7:0]), 32'ha0, "blocked launch");
      chk(32'(nrd), 32'h0, "blocked reads");
      coll = 1'b1;
      cmd(8'h01, 24'h0, 32'h0200, 32'h0, 8'hc0, 2);
      coll = 1'b0;
      $display("test misc done");
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, mcu_read, full_erase_done, coll} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      bad_count = 0;
      tests_run = 0;
      nrd = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_section;
      t_errors;
      t_pgm;
      t_prot;
      t_misc;
      complete_run;
   end
   // Whole run needs about 760 cycles
   initial
   begin
      #500000;
      bad_count++;
      complete_run;
   end
endmodule
